// >>> src/iomc_bit_mapper.sv
`timescale 1ns/1ps
`default_nettype none
`include "iomc_params.svh"
module iomc_bit_mapper
  import iomc_pkg::*;
(
  // layout selection
  input  wire logic [2:0]  mode,
  input  wire logic [79:0] mapFlat,
  // channel order to word and back
  input  wire logic [15:0] chanIn,
  input  wire logic [15:0] wordIn,
  output logic      [15:0] wordOut,
  output logic      [15:0] chanOut
);
  // word position of a channel; channel index is port*2 plus B flag
  function automatic logic [4:0] iomc_pos(input logic [2:0] md, input logic [3:0] ch, input logic [4:0] fr);
    unique case (md)
      `IOMC_MODE_DEFAULT: iomc_pos = {1'b0, ch};
      `IOMC_MODE_SWAP:    iomc_pos = {1'b0, ch ^ 4'h8};
      `IOMC_MODE_A_LOW:   iomc_pos = {1'b0, ch[0], ch[3:1]};
      `IOMC_MODE_B_LOW:   iomc_pos = {1'b0, ~ch[0], ch[3:1]};
      `IOMC_MODE_FREE:    iomc_pos = fr;
      default:            iomc_pos = {1'b0, ch};
    endcase
  endfunction : iomc_pos

  // one position table serves both directions
  always_comb
  begin
    logic [4:0] p;
    p       = 5'h00;
    wordOut = 16'h0000;
    chanOut = 16'h0000;
    for (int c = 0; c < 16; c++)
    begin
      p = iomc_pos(mode, 4'(c), mapFlat[c*5 +: 5]);
      // inactive channels neither read nor drive a bit
      if (!p[4])
      begin
        wordOut[p[3:0]] = chanIn[c];
        chanOut[c]      = wordIn[p[3:0]];
      end
    end
  end
endmodule : iomc_bit_mapper
`default_nettype wire

// >>> src/iomc_map_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "iomc_params.svh"
module iomc_map_check
  import iomc_pkg::*;
(
  // per-channel bit positions, channel 0 in the low bits
  input  wire logic [79:0] mapFlat,
  // table usable for free mapping
  output logic             mapOk
);
  // duplicate and range search over the active entries
  always_comb
  begin
    logic [15:0] used;
    logic [4:0]  ent;
    used  = 16'h0000;
    ent   = 5'h00;
    mapOk = 1'b1;
    for (int c = 0; c < 16; c++)
    begin
      ent = mapFlat[c*5 +: 5];
      if (ent > `IOMC_MAP_INACTIVE)
        mapOk = 1'b0;
      else if (ent != `IOMC_MAP_INACTIVE)
      begin
        if (used[ent[3:0]])
          mapOk = 1'b0;
        used[ent[3:0]] = 1'b1;
      end
    end
  end
endmodule : iomc_map_check
`default_nettype wire

// >>> src/iomc_params.svh
`ifndef IOMC_PARAMS_SVH
`define IOMC_PARAMS_SVH

// general setting offsets inside the configuration assembly
`define IOMC_OFS_FORCE_LOCK   8'h01
`define IOMC_OFS_WEB_LOCK     8'h02
`define IOMC_OFS_OUT_SRC      8'h03
`define IOMC_OFS_SUPPLY_REP   8'h04
`define IOMC_OFS_NOSUP_REP    8'h05
`define IOMC_OFS_OBJ_LOCK     8'h18
`define IOMC_OFS_EXT_LOCK     8'h19
`define IOMC_OFS_MAP_MODE     8'h1f
`define IOMC_OFS_MAP_FIRST    9'h020
`define IOMC_OFS_MAP_LAST     9'h02f
// storage slots of the general settings
`define IOMC_SLOT_FORCE       3'h0
`define IOMC_SLOT_WEB         3'h1
`define IOMC_SLOT_SRC         3'h2
`define IOMC_SLOT_SUPPLY      3'h3
`define IOMC_SLOT_NOSUP       3'h4
`define IOMC_SLOT_OBJ         3'h5
`define IOMC_SLOT_EXT         3'h6
`define IOMC_SLOT_MODE        3'h7
// values and reset values
`define IOMC_GEN_RESET        8'h00
`define IOMC_ON               8'h01
`define IOMC_BOOL_MAX         8'h01
`define IOMC_MODE_MAX         8'h04
`define IOMC_MAP_MAX          8'h10
`define IOMC_MAP_INACTIVE     5'h10
`define IOMC_MODE_DEFAULT     3'h0
`define IOMC_MODE_SWAP        3'h1
`define IOMC_MODE_A_LOW       3'h2
`define IOMC_MODE_B_LOW       3'h3
`define IOMC_MODE_FREE        3'h4
// connection figures
`define IOMC_CFG_SIZE         10'h1e0
`define IOMC_ASM_OT_OWNER     8'h82
`define IOMC_ASM_TO           8'h83
`define IOMC_ASM_OT_LISTEN    8'hc0
`define IOMC_OT_SIZE          9'h104
`define IOMC_TO_SIZE          9'h1be
`define IOMC_LISTEN_OT_SIZE   9'h000
`define IOMC_RUN_BIT          0
// timing: least packet interval in microseconds, clock in MHz
`define IOMC_RPI_MIN_US       16'h03e8
`define IOMC_CLK_MHZ          25
`define IOMC_RPI_MIN_CYCLES   (`IOMC_RPI_MIN_US * `IOMC_CLK_MHZ)
`endif

// >>> src/iomc_pkg.sv
`default_nettype none
`include "iomc_params.svh"
package iomc_pkg;
  typedef enum logic [1:0] {ERR_NONE, ERR_SIZE, ERR_VALUE, ERR_MAP} iomc_err_type;
  typedef enum logic {CFG_IDLE, CFG_RECV} iomc_cfg_state_type;

  // offset to storage slot, top bit marks a hit
  function automatic logic [3:0] iomc_gen_slot(input logic [7:0] ofs);
    unique case (ofs)
      `IOMC_OFS_FORCE_LOCK: iomc_gen_slot = {1'b1, `IOMC_SLOT_FORCE};
      `IOMC_OFS_WEB_LOCK:   iomc_gen_slot = {1'b1, `IOMC_SLOT_WEB};
      `IOMC_OFS_OUT_SRC:    iomc_gen_slot = {1'b1, `IOMC_SLOT_SRC};
      `IOMC_OFS_SUPPLY_REP: iomc_gen_slot = {1'b1, `IOMC_SLOT_SUPPLY};
      `IOMC_OFS_NOSUP_REP:  iomc_gen_slot = {1'b1, `IOMC_SLOT_NOSUP};
      `IOMC_OFS_OBJ_LOCK:   iomc_gen_slot = {1'b1, `IOMC_SLOT_OBJ};
      `IOMC_OFS_EXT_LOCK:   iomc_gen_slot = {1'b1, `IOMC_SLOT_EXT};
      `IOMC_OFS_MAP_MODE:   iomc_gen_slot = {1'b1, `IOMC_SLOT_MODE};
      default:              iomc_gen_slot = 4'h0;
    endcase
  endfunction : iomc_gen_slot

  // range check of a general setting value
  function automatic logic iomc_value_ok(input logic [2:0] slot, input logic [7:0] val);
    if (slot == `IOMC_SLOT_MODE)
      iomc_value_ok = (val <= `IOMC_MODE_MAX);
    else
      iomc_value_ok = (val <= `IOMC_BOOL_MAX);
  endfunction : iomc_value_ok
endpackage : iomc_pkg
`default_nettype wire

// >>> src/iomc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "iomc_params.svh"
module iomc_top
  import iomc_pkg::*;
#(
  parameter int RPI_MIN_CYCLES = `IOMC_RPI_MIN_CYCLES
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // configuration assembly stream
  input  wire logic        cfgValid,
  input  wire logic [7:0]  cfgByte,
  input  wire logic        cfgLast,
  input  wire logic        cfgEmpty,
  output logic             cfgDone,
  output logic             cfgError,
  output logic [1:0]       cfgErrCode,
  // connection management
  input  wire logic        conOpenReq,
  input  wire logic        conIsListen,
  input  wire logic [15:0] conRpiUs,
  input  wire logic [7:0]  conOtAsm,
  input  wire logic [7:0]  conToAsm,
  input  wire logic [8:0]  conOtSize,
  input  wire logic [8:0]  conToSize,
  input  wire logic        conToMcast,
  input  wire logic        conClose,
  output logic             conAccept,
  output logic             conReject,
  output logic             conActive,
  output logic             conListen,
  // originator to target frames
  input  wire logic        otValid,
  input  wire logic [31:0] otHeader,
  input  wire logic [15:0] otCtrlWord,
  output logic             runMode,
  // channel data
  input  wire logic [15:0] ioLinkCtrl,
  input  wire logic [15:0] diChan,
  output logic      [15:0] doChan,
  output logic      [15:0] diStatusWord,
  // object and external writes
  input  wire logic        objWrReq,
  input  wire logic [7:0]  objWrAddr,
  input  wire logic [7:0]  objWrData,
  output logic             objWrAck,
  output logic             objWrRej,
  input  wire logic        extWrReq,
  input  wire logic [7:0]  extWrAddr,
  input  wire logic [7:0]  extWrData,
  output logic             extWrAck,
  output logic             extWrRej,
  // force, web and fault reports
  input  wire logic        forceReq,
  output logic             forceGrant,
  output logic             forceRefuse,
  output logic             webReachable,
  input  wire logic        supplyFaultIn,
  output logic             supplyFaultReport,
  input  wire logic        noSupplyDoFaultIn,
  output logic             noSupplyDoFaultReport,
  // register read
  input  wire logic [7:0]  rdAddr,
  output logic      [7:0]  rdData
);
  localparam logic [15:0] GapMin = 16'(RPI_MIN_CYCLES);

  // stored settings and assembly shadow
  logic [7:0]  gen_q [8];
  logic [7:0]  gen_d [8];
  logic [7:0]  shGen_q [8];
  logic [7:0]  shGen_d [8];
  logic [79:0] map_q, map_d, shMap_q, shMap_d;
  logic [8:0]  cfgIdx_q, cfgIdx_d;
  logic        cfgBad_q, cfgBad_d;
  iomc_cfg_state_type cfgState_q, cfgState_d;
  logic        cfgDone_q, cfgDone_d, cfgError_q, cfgError_d;
  logic [1:0]  cfgErrCode_q, cfgErrCode_d;
  logic        objAck_q, objAck_d, objRej_q, objRej_d;
  logic        extAck_q, extAck_d, extRej_q, extRej_d;
  logic        shMapOk;
  // connection and frame state
  logic        conAccept_q, conAccept_d, conReject_q, conReject_d;
  logic        conActive_q, conActive_d, conListen_q, conListen_d;
  logic        run_q, run_d;
  logic [15:0] ctrlWord_q, ctrlWord_d, gap_q, gap_d;
  // output stage
  logic [15:0] doChan_q, doChan_d, diWord_q, diWord_d;
  logic        fGrant_q, fGrant_d, fRefuse_q, fRefuse_d, web_q, web_d;
  logic        supRep_q, supRep_d, noSupRep_q, noSupRep_d;
  logic [7:0]  rdData_q, rdData_d;
  logic [15:0] ctrlChan, diWord;

  // free table check on the received shadow, before commit
  iomc_map_check u_check (
    .mapFlat (shMap_q),
    .mapOk   (shMapOk)
  );

  iomc_bit_mapper u_mapper (
    .mode    (gen_q[`IOMC_SLOT_MODE][2:0]),
    .mapFlat (map_q),
    .chanIn  (diChan),
    .wordIn  (ctrlWord_q),
    .wordOut (diWord),
    .chanOut (ctrlChan)
  );

  // configuration paths: assembly stream, object writes, external writes
  always_comb
  begin
    logic [8:0] pos;
    logic [3:0] slot;
    logic [3:0] wSlot;
    logic       commit;
    pos          = (cfgState_q == CFG_IDLE) ? 9'h000 : cfgIdx_q;
    slot         = iomc_gen_slot(pos[7:0]);
    wSlot        = 4'h0;
    commit       = 1'b0;
    gen_d        = gen_q;
    map_d        = map_q;
    shGen_d      = shGen_q;
    shMap_d      = shMap_q;
    cfgIdx_d     = cfgIdx_q;
    cfgBad_d     = cfgBad_q;
    cfgState_d   = cfgState_q;
    cfgDone_d    = 1'b0;
    cfgError_d   = 1'b0;
    cfgErrCode_d = cfgErrCode_q;
    objAck_d     = 1'b0;
    objRej_d     = 1'b0;
    extAck_d     = 1'b0;
    extRej_d     = 1'b0;
    if (cfgValid)
    begin
      if (cfgState_q == CFG_IDLE)
        cfgBad_d = 1'b0;
      // out-of-range general value spoils the assembly
      if (slot[3] && pos[8] == 1'b0)
      begin
        shGen_d[slot[2:0]] = cfgByte;
        if (!iomc_value_ok(slot[2:0], cfgByte))
          cfgBad_d = 1'b1;
      end
      if (pos >= `IOMC_OFS_MAP_FIRST && pos <= `IOMC_OFS_MAP_LAST)
      begin
        shMap_d[pos[3:0]*5 +: 5] = cfgByte[4:0];
        if (cfgByte > `IOMC_MAP_MAX)
          cfgBad_d = 1'b1;
      end
      if (cfgLast)
      begin
        cfgState_d = CFG_IDLE;
        // only the full-size assembly is taken
        if ({1'b0, pos} + 10'h001 != `IOMC_CFG_SIZE)
        begin
          cfgError_d   = 1'b1;
          cfgErrCode_d = ERR_SIZE;
        end
        else if (cfgBad_d)
        begin
          cfgError_d   = 1'b1;
          cfgErrCode_d = ERR_VALUE;
        end
        else if (shGen_q[`IOMC_SLOT_MODE][2:0] == `IOMC_MODE_FREE && !shMapOk)
        begin
          cfgError_d   = 1'b1;
          cfgErrCode_d = ERR_MAP;
        end
        else
        begin
          commit       = 1'b1;
          cfgDone_d    = 1'b1;
          cfgErrCode_d = ERR_NONE;
        end
      end
      else
      begin
        cfgState_d = CFG_RECV;
        // saturate so an overlong stream still reads as a size error
        cfgIdx_d   = (pos == 9'h1ff) ? pos : pos + 9'h001;
      end
    end
    else if (cfgEmpty && cfgState_q == CFG_IDLE)
    begin
      cfgDone_d    = 1'b1;
      cfgErrCode_d = ERR_NONE;
    end
    // object path
    wSlot = iomc_gen_slot(objWrAddr);
    if (objWrReq)
    begin
      if (commit || !wSlot[3] || !iomc_value_ok(wSlot[2:0], objWrData)
          || (gen_q[`IOMC_SLOT_OBJ] == `IOMC_ON && conActive_q))
        objRej_d = 1'b1;
      else
      begin
        gen_d[wSlot[2:0]] = objWrData;
        objAck_d          = 1'b1;
      end
    end
    // external path, applied after the object path
    wSlot = iomc_gen_slot(extWrAddr);
    if (extWrReq)
    begin
      // external lock only counts while connected
      if (commit || !wSlot[3] || !iomc_value_ok(wSlot[2:0], extWrData)
          || (gen_q[`IOMC_SLOT_EXT] != `IOMC_GEN_RESET && conActive_q))
        extRej_d = 1'b1;
      else
      begin
        gen_d[wSlot[2:0]] = extWrData;
        extAck_d          = 1'b1;
      end
    end
    // assembly overwrites everything and blocks other writes
    if (commit)
    begin
      gen_d = shGen_q;
      map_d = shMap_q;
    end
  end

  // configuration registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 8; i++)
      begin
        gen_q[i]   <= `IOMC_GEN_RESET;
        shGen_q[i] <= `IOMC_GEN_RESET;
      end
      // free table defaults to each channel's own bit
      for (int c = 0; c < 16; c++)
      begin
        map_q[c*5 +: 5]   <= 5'(c);
        shMap_q[c*5 +: 5] <= 5'(c);
      end
      cfgIdx_q     <= 9'h000;
      cfgBad_q     <= 1'b0;
      cfgState_q   <= CFG_IDLE;
      cfgDone_q    <= 1'b0;
      cfgError_q   <= 1'b0;
      cfgErrCode_q <= ERR_NONE;
      objAck_q     <= 1'b0;
      objRej_q     <= 1'b0;
      extAck_q     <= 1'b0;
      extRej_q     <= 1'b0;
    end
    else
    begin
      gen_q        <= gen_d;
      shGen_q      <= shGen_d;
      map_q        <= map_d;
      shMap_q      <= shMap_d;
      cfgIdx_q     <= cfgIdx_d;
      cfgBad_q     <= cfgBad_d;
      cfgState_q   <= cfgState_d;
      cfgDone_q    <= cfgDone_d;
      cfgError_q   <= cfgError_d;
      cfgErrCode_q <= cfgErrCode_d;
      objAck_q     <= objAck_d;
      objRej_q     <= objRej_d;
      extAck_q     <= extAck_d;
      extRej_q     <= extRej_d;
    end
  end

  // connection set-up checks and cyclic frame intake
  always_comb
  begin
    logic okOwner;
    logic okListen;
    okOwner     = conOtAsm == `IOMC_ASM_OT_OWNER && conOtSize == `IOMC_OT_SIZE;
    okListen    = conOtAsm == `IOMC_ASM_OT_LISTEN && conOtSize == `IOMC_LISTEN_OT_SIZE;
    conAccept_d = 1'b0;
    conReject_d = 1'b0;
    conActive_d = conActive_q;
    conListen_d = conListen_q;
    run_d       = run_q;
    ctrlWord_d  = ctrlWord_q;
    gap_d       = (gap_q < GapMin) ? gap_q + 16'h0001 : gap_q;
    if (conClose)
    begin
      conActive_d = 1'b0;
      conListen_d = 1'b0;
      run_d       = 1'b0;
    end
    else if (conOpenReq)
    begin
      // least interval, input assembly and fan-out
      if (conRpiUs >= `IOMC_RPI_MIN_US && conToAsm == `IOMC_ASM_TO
          && conToSize == `IOMC_TO_SIZE && (conIsListen ? (okListen && conToMcast) : okOwner))
      begin
        conAccept_d = 1'b1;
        conActive_d = 1'b1;
        conListen_d = conIsListen;
      end
      else
        conReject_d = 1'b1;
    end
    // frames closer than the least interval are dropped
    else if (otValid && conActive_q && !conListen_q && gap_q >= GapMin)
    begin
      run_d      = otHeader[`IOMC_RUN_BIT];
      ctrlWord_d = otCtrlWord;
      gap_d      = 16'h0001;
    end
  end

  // connection registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      conAccept_q <= 1'b0;
      conReject_q <= 1'b0;
      conActive_q <= 1'b0;
      conListen_q <= 1'b0;
      run_q       <= 1'b0;
      ctrlWord_q  <= 16'h0000;
      gap_q       <= GapMin;
    end
    else
    begin
      conAccept_q <= conAccept_d;
      conReject_q <= conReject_d;
      conActive_q <= conActive_d;
      conListen_q <= conListen_d;
      run_q       <= run_d;
      ctrlWord_q  <= ctrlWord_d;
      gap_q       <= gap_d;
    end
  end

  // output stage: doChan idle while not in run
  always_comb
  begin
    logic [3:0] rSlot;
    rSlot = iomc_gen_slot(rdAddr);
    // one control source for the outputs
    if (!run_q)
      doChan_d = 16'h0000;
    else if (gen_q[`IOMC_SLOT_SRC] == `IOMC_ON)
      doChan_d = ioLinkCtrl;
    else
      doChan_d = ctrlChan;
    diWord_d   = diWord;
    fGrant_d   = forceReq && gen_q[`IOMC_SLOT_FORCE] != `IOMC_ON;
    fRefuse_d  = forceReq && gen_q[`IOMC_SLOT_FORCE] == `IOMC_ON;
    // web pages closed under the lock
    web_d      = gen_q[`IOMC_SLOT_WEB] != `IOMC_ON;
    supRep_d   = supplyFaultIn && gen_q[`IOMC_SLOT_SUPPLY] == `IOMC_ON;
    noSupRep_d = noSupplyDoFaultIn && gen_q[`IOMC_SLOT_NOSUP] == `IOMC_ON;
    rdData_d   = rSlot[3] ? gen_q[rSlot[2:0]] : 8'h00;
  end

  // output registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      doChan_q   <= 16'h0000;
      diWord_q   <= 16'h0000;
      fGrant_q   <= 1'b0;
      fRefuse_q  <= 1'b0;
      web_q      <= 1'b0;
      supRep_q   <= 1'b0;
      noSupRep_q <= 1'b0;
      rdData_q   <= 8'h00;
    end
    else
    begin
      doChan_q   <= doChan_d;
      diWord_q   <= diWord_d;
      fGrant_q   <= fGrant_d;
      fRefuse_q  <= fRefuse_d;
      web_q      <= web_d;
      supRep_q   <= supRep_d;
      noSupRep_q <= noSupRep_d;
      rdData_q   <= rdData_d;
    end
  end

  assign cfgDone               = cfgDone_q;
  assign cfgError              = cfgError_q;
  assign cfgErrCode            = cfgErrCode_q;
  assign conAccept             = conAccept_q;
  assign conReject             = conReject_q;
  assign conActive             = conActive_q;
  assign conListen             = conListen_q;
  assign runMode               = run_q;
  assign doChan                = doChan_q;
  assign diStatusWord          = diWord_q;
  assign objWrAck              = objAck_q;
  assign objWrRej              = objRej_q;
  assign extWrAck              = extAck_q;
  assign extWrRej              = extRej_q;
  assign forceGrant            = fGrant_q;
  assign forceRefuse           = fRefuse_q;
  assign webReachable          = web_q;
  assign supplyFaultReport     = supRep_q;
  assign noSupplyDoFaultReport = noSupRep_q;
  assign rdData                = rdData_q;

  // checks on the block's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence lockedForce;
    forceReq && gen_q[`IOMC_SLOT_FORCE] == `IOMC_ON;
  endsequence
  sequence shortRpiOpen;
    conOpenReq && !conClose && conRpiUs < `IOMC_RPI_MIN_US;
  endsequence
  sequence lockedObjWrite;
    objWrReq && conActive_q && gen_q[`IOMC_SLOT_OBJ] == `IOMC_ON;
  endsequence
  sequence rejectedCfg;
    cfgValid && cfgLast && !objWrReq && !extWrReq ##1 cfgError;
  endsequence

  force_refused_a: assert property (lockedForce |=> forceRefuse && !forceGrant)
    else $error("force granted under lock");
  web_closed_a: assert property (gen_q[`IOMC_SLOT_WEB] == `IOMC_ON |=> !webReachable)
    else $error("web reachable under lock");
  supply_gate_a: assert property (gen_q[`IOMC_SLOT_SUPPLY] == `IOMC_GEN_RESET |=> !supplyFaultReport)
    else $error("supply fault reported while disabled");
  nosup_gate_a: assert property (gen_q[`IOMC_SLOT_NOSUP] == `IOMC_GEN_RESET |=> !noSupplyDoFaultReport)
    else $error("output fault reported while disabled");
  obj_locked_a: assert property (lockedObjWrite |=> objWrRej && !objWrAck)
    else $error("object write taken under lock");
  ext_locked_a: assert property (extWrReq && conActive_q && gen_q[`IOMC_SLOT_EXT] != 8'h00 |=> extWrRej)
    else $error("external write taken under lock");
  rpi_short_a: assert property (shortRpiOpen |=> conReject && !conAccept && $stable(conActive))
    else $error("short interval accepted");
  empty_cfg_a: assert property (cfgEmpty && !cfgValid && cfgState_q == CFG_IDLE |=> cfgDone && !cfgError)
    else $error("empty assembly not accepted");
  bad_cfg_a: assert property (rejectedCfg |-> $stable(gen_q[`IOMC_SLOT_MODE]) && $stable(map_q))
    else $error("settings changed on rejected assembly");
  default_map_a: assert property (run_q && gen_q[`IOMC_SLOT_MODE] == 8'h00 && gen_q[`IOMC_SLOT_SRC] == 8'h00
                                  |=> doChan == $past(ctrlWord_q))
    else $error("default layout not in channel order");
endmodule : iomc_top
`default_nettype wire

// >>> tb/iomc_plc.sv
`timescale 1ns/1ps
`default_nettype none
module iomc_plc
(
  // clock
  input  wire logic       clk,
  // configuration assembly stream
  output logic            cfgValid,
  output logic      [7:0] cfgByte,
  output logic            cfgLast,
  output logic            cfgEmpty
);
  // idle stream at time zero
  initial
  begin
    {cfgValid, cfgByte, cfgLast, cfgEmpty} = '0;
  end
  // full assembly image
  // locks and supply report on, free map left zero so it is duplicated
  task automatic send(input logic [7:0] mode);
    for (int i = 0; i < 480; i++)
    begin
      @(posedge clk);
      #1;
      cfgValid = 1'b1;
      cfgByte = (i inside {1, 2, 4, 24, 25}) ? 8'h01 : ((i == 31) ? mode : 8'h00);
      cfgLast = (i == 479);
    end
    @(posedge clk);
    #1;
    cfgValid = 1'b0;
    cfgLast = 1'b0;
    cfgByte = ~cfgByte; // released bus must not repeat data
  endtask : send
  task automatic send_empty();
    @(posedge clk);
    #1;
    cfgEmpty = 1'b1;
    @(posedge clk);
    #1;
    cfgEmpty = 1'b0;
  endtask : send_empty
endmodule : iomc_plc
`default_nettype wire

// >>> tb/iomc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module iomc_top_test;
  logic        clk, rst, cfgValid, cfgLast, cfgEmpty, cfgDone, cfgError, conOpenReq, conAccept, conReject;
  logic        listen, otValid, runMode, objWrReq, objWrRej, extWrReq, extWrRej, forceReq, forceRefuse;
  logic        webReachable, sup, supRep, nsRep;
  logic        conClose, conActive, conListen, objWrAck, extWrAck, forceGrant;
  logic [1:0]  cfgErrCode;
  logic [7:0]  cfgByte, otAsm, wa, wd, rdAddr, rdData, toAsm;
  logic [8:0]  otSize, toSize;
  logic [15:0] rpi, diChan, otCtrlWord, doChan, diStatusWord, ioCtrl;
  logic [31:0] otHeader;
  int          n_errors = 0;
  int          cmp_count = 0;

  iomc_top #(.RPI_MIN_CYCLES(8)) iomc_top_i (.clk, .rst, .cfgValid, .cfgByte, .cfgLast, .cfgEmpty, .cfgDone,
    .cfgError, .cfgErrCode, .conOpenReq, .conIsListen(listen), .conRpiUs(rpi), .conOtAsm(otAsm),
    .conToAsm(toAsm), .conOtSize(otSize), .conToSize(toSize), .conToMcast(listen), .conClose,
    .conAccept, .conReject, .conActive, .conListen, .otValid, .otHeader, .otCtrlWord, .runMode,
    .ioLinkCtrl(ioCtrl), .diChan, .doChan, .diStatusWord, .objWrReq, .objWrAddr(wa), .objWrData(wd),
    .objWrAck, .objWrRej, .extWrReq, .extWrAddr(wa), .extWrData(wd), .extWrAck, .extWrRej, .forceReq,
    .forceGrant, .forceRefuse, .webReachable, .supplyFaultIn(sup), .supplyFaultReport(supRep),
    .noSupplyDoFaultIn(sup), .noSupplyDoFaultReport(nsRep), .rdAddr, .rdData);
  iomc_plc iomc_plc_i (.clk, .cfgValid, .cfgByte, .cfgLast, .cfgEmpty);

  // clock, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // watchdog, tests need about 60 us
  initial
  begin
    #200000;
    n_errors++;
    close_out();
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("Error %0t: got %h want %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk
  task automatic close_out();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // open request, answered one cycle later
  task automatic con(input logic [15:0] r, input logic [7:0] a, input logic [8:0] s, input logic l, input logic ok);
    tick();
    {rpi, otAsm, otSize, listen, conOpenReq} = {r, a, s, l, 1'b1};
    tick();
    conOpenReq = 1'b0;
    chk({conAccept, conReject}, {ok, !ok});
  endtask : con
  // one object (obj=1) or external write, answered one cycle later
  task automatic wr(input logic obj, input logic [7:0] a, input logic [7:0] d, input logic ok);
    tick();
    {wa, wd, objWrReq, extWrReq} = {a, d, obj, !obj};
    tick();
    {objWrReq, extWrReq} = 2'b00;
    chk({objWrAck, objWrRej, extWrAck, extWrRej}, obj ? {ok, !ok, 2'b00} : {2'b00, ok, !ok});
  endtask : wr
  // owner frame in run; doChan settles two edges on
  task automatic frame(input logic [15:0] w);
    {otHeader, otCtrlWord, otValid} = {32'h0000_0001, w, 1'b1};
    tick();
    otValid = 1'b0;
    chk(runMode, 1'b1);
    tick();
  endtask : frame
  // interval floor, listen-only, then owner left open
  task automatic t_conn();
    con(16'd999, 8'd130, 9'd260, 1'b0, 1'b0);
    con(16'd1000, 8'd192, 9'd0, 1'b1, 1'b1);
    con(16'd1000, 8'd130, 9'd260, 1'b0, 1'b1);
    frame(16'h0102);
    chk(doChan, 16'h0102);
    // second frame inside the least interval is dropped
    frame(16'hffff);
    chk(doChan, 16'h0102);
  endtask : t_conn
  // mode 2 assembly with locks, mapping both ways, then locked writes
  task automatic t_config();
    iomc_plc_i.send(8'h02);
    chk(cfgDone, 1'b1);
    {rdAddr, diChan} = {8'h1f, 16'h0003};
    tick();
    tick();
    chk(rdData, 8'h02);
    chk(diStatusWord, 16'h0101);
    chk({webReachable, supRep, nsRep}, 3'b010);
    frame(16'h0101);
    chk(doChan, 16'h0003);
    {wa, wd, objWrReq, extWrReq, forceReq} = {8'h02, 8'h00, 3'b111};
    tick();
    {objWrReq, extWrReq, forceReq} = 3'b000;
    chk({objWrRej, extWrRej, forceRefuse}, 3'b111);
  endtask : t_config
  // bad value, duplicated free map, then empty form
  task automatic t_refuse();
    iomc_plc_i.send(8'h05);
    chk({cfgError, cfgErrCode}, 3'b110);
    iomc_plc_i.send(8'h04);
    chk({cfgError, cfgErrCode}, 3'b111);
    tick();
    chk(rdData, 8'h02);
    iomc_plc_i.send_empty();
    chk(cfgDone, 1'b1);
  endtask : t_refuse
  // close, writes while unconnected, fixed layouts, link-byte source
  task automatic t_owner();
    tick();
    conClose = 1'b1;
    tick();
    conClose = 1'b0;
    chk({conActive, runMode}, 2'b00);
    wr(1'b1, 8'h05, 8'h01, 1'b1);
    wr(1'b1, 8'h1f, 8'h07, 1'b0);
    wr(1'b0, 8'h01, 8'h00, 1'b1);
    wr(1'b0, 8'h03, 8'h01, 1'b1);
    wr(1'b0, 8'h1f, 8'h03, 1'b1);
    diChan = 16'h0006;
    tick();
    chk(diStatusWord, 16'h0201);
    wr(1'b0, 8'h1f, 8'h01, 1'b1);
    tick();
    chk(diStatusWord, 16'h0600);
    chk(nsRep, 1'b1);
    forceReq = 1'b1;
    tick();
    forceReq = 1'b0;
    chk({forceGrant, forceRefuse}, 2'b10);
    toAsm = 8'h82;
    con(16'h03e8, 8'h82, 9'h104, 1'b0, 1'b0);
    toAsm = 8'h83;
    con(16'h03e8, 8'h82, 9'h104, 1'b0, 1'b1);
    chk({conActive, conListen}, 2'b10);
    ioCtrl = 16'h8001;
    frame(16'h0000);
    chk(doChan, 16'h8001);
  endtask : t_owner
  // reset for 20 cycles, then the scenarios
  initial
  begin
    {conOpenReq, listen, otValid, objWrReq, extWrReq, forceReq, rpi, otAsm, otSize} = '0;
    {wa, wd, rdAddr, diChan, otHeader, otCtrlWord, conClose, ioCtrl} = '0;
    {toAsm, toSize} = {8'h83, 9'h1be};
    rst = 1'b1;
    sup = 1'b1;
    repeat (20) tick();
    rst = 1'b0;
    tick();
    tick();
    chk({webReachable, supRep}, 2'b10);
    t_conn();
    t_config();
    t_refuse();
    t_owner();
    close_out();
  end
endmodule : iomc_top_test
`default_nettype wire
